// file: hw/shs_alu.sv
// Purpose : Execution slice for signed halving / parallel subtracts and bit tests.
// Assumes : One operation per enabled cycle, operands already read and shifted.
// Notes   : Results register one cycle after the request; flags live here.
//
// Contract
// - Exchange add: top A plus low B, halved, top
// - Exchange add: low A minus top B, halved, low
// - Sub-add exchange: top A-low B, low A+top B halved
// - Halving exchange ops keep condition flags unchanged
// - Halving halfword subtract, each lane halved, written
// - Halving byte subtract, four lanes halved, written
// - Halving subtracts keep condition flags unchanged
// - Parallel halfword subtract writes low sixteen bits
// - Halfword GE pairs set 11 when difference nonnegative
// - Parallel byte subtract writes low eight bits
// - Byte GE bit set when its difference nonnegative
// - Bit test ANDs, updates flags, writes nothing
// - Equivalence test XORs, updates flags, writes nothing
// - Tests set N and Z from result
// - Tests may load C from shifter carry
// - Tests leave overflow flag unchanged
// - Updates happen only when condition passes
// - Omitted destination means first operand register
`timescale 1ns/10ps
module shs_alu #(
   parameter int WORD_W = shs_pkg::WORD_W
) (
   input  wire logic                             mclk_i,
   input  wire logic                             reset_n_i,
   input  wire logic                             clk_en_i,
   input  wire logic                             op_valid_i,
   input  wire logic [2:0]                       op_sel_i,
   input  wire logic [shs_pkg::COND_W-1:0]       cond_i,
   input  wire logic [WORD_W-1:0]                first_operand_i,
   input  wire logic [WORD_W-1:0]                second_operand_i,
   input  wire logic                             shifter_carry_i,
   input  wire logic                             shifter_carry_valid_i,
   input  wire logic [shs_pkg::REG_IDX_W-1:0]    first_operand_idx_i,
   input  wire logic [shs_pkg::REG_IDX_W-1:0]    dest_idx_i,
   input  wire logic                             dest_present_i,
   output logic      [WORD_W-1:0]                result_o,
   output logic      [shs_pkg::REG_IDX_W-1:0]    result_idx_o,
   output logic                                  result_we_o,
   output logic      [3:0]                       flags_o,
   output logic      [shs_pkg::GE_W-1:0]         lane_greater_equal_flags_o,
   output logic                                  done_o,
   output logic                                  operand_fault_o
);

   // ***************************************************
   // Elaboration check
   // ***************************************************
   if (WORD_W != shs_pkg::WORD_W) begin : g_bad_word
      $error("shs_alu: only a 32-bit word is supported");
   end

   localparam int HW = shs_pkg::HALF_W;
   localparam int BW = shs_pkg::BYTE_W;
   localparam int NB = WORD_W / BW;

   // ***************************************************
   // Condition evaluation
   // ***************************************************
   // Decodes a condition against a flag nibble; shared by the pass test
   function automatic logic shs_cond_pass(input logic [3:0] cc, input logic [3:0] f);
      logic n;
      logic z;
      logic c;
      logic v;
      n = f[shs_pkg::FLAG_N];
      z = f[shs_pkg::FLAG_Z];
      c = f[shs_pkg::FLAG_C];
      v = f[shs_pkg::FLAG_V];
      case (cc)
         shs_pkg::CC_EQ: shs_cond_pass = z;
         shs_pkg::CC_NE: shs_cond_pass = ~z;
         shs_pkg::CC_CS: shs_cond_pass = c;
         shs_pkg::CC_CC: shs_cond_pass = ~c;
         shs_pkg::CC_MI: shs_cond_pass = n;
         shs_pkg::CC_PL: shs_cond_pass = ~n;
         shs_pkg::CC_VS: shs_cond_pass = v;
         shs_pkg::CC_VC: shs_cond_pass = ~v;
         shs_pkg::CC_HI: shs_cond_pass = c & ~z;
         shs_pkg::CC_LS: shs_cond_pass = ~c | z;
         shs_pkg::CC_GE: shs_cond_pass = (n == v);
         shs_pkg::CC_LT: shs_cond_pass = (n != v);
         shs_pkg::CC_GT: shs_cond_pass = ~z & (n == v);
         shs_pkg::CC_LE: shs_cond_pass = z | (n != v);
         default:        shs_cond_pass = 1'b1;
      endcase
   endfunction : shs_cond_pass

   // Flags seen by the next operation are the registered ones, so back-to-back
   // conditional ops see the previous result with no bypass needed.
   logic      [3:0]              flags_reg;
   logic      [3:0]              flags_next;
   logic      [shs_pkg::GE_W-1:0] ge_reg;
   logic      [shs_pkg::GE_W-1:0] ge_next;
   logic                         cond_ok;
   logic                         fire;
   shs_pkg::shs_op_t             op;

   assign op      = shs_pkg::shs_op_t'(op_sel_i);
   assign cond_ok = shs_cond_pass(cond_i, flags_reg);
   assign fire    = op_valid_i & cond_ok;

   // ***************************************************
   // Lane arithmetic
   // ***************************************************
   // Halfword lanes: operand pairing depends on exchange ops
   logic [HW-1:0] h_a    [2];
   logic [HW-1:0] h_b    [2];
   logic          h_sub  [2];
   logic [HW-1:0] h_wrap [2];
   logic [HW-1:0] h_half [2];
   logic          h_nn   [2];

   // Pick operands and add/subtract per halfword lane
   always_comb begin
      h_a[0]   = first_operand_i[HW-1:0];
      h_a[1]   = first_operand_i[WORD_W-1:HW];
      h_b[0]   = second_operand_i[HW-1:0];
      h_b[1]   = second_operand_i[WORD_W-1:HW];
      h_sub[0] = 1'b1;
      h_sub[1] = 1'b1;
      case (op)
         shs_pkg::SHS_OP_HASX: begin
            h_b[1]   = second_operand_i[HW-1:0];
            h_sub[1] = 1'b0;
            h_b[0]   = second_operand_i[WORD_W-1:HW];
         end
         shs_pkg::SHS_OP_HSAX: begin
            h_b[1]   = second_operand_i[HW-1:0];
            h_b[0]   = second_operand_i[WORD_W-1:HW];
            h_sub[0] = 1'b0;
         end
         default: begin
            h_sub[0] = 1'b1;
         end
      endcase
   end

   // Byte lanes always subtract matching bytes
   logic [BW-1:0] b_wrap [NB];
   logic [BW-1:0] b_half [NB];
   logic          b_nn   [NB];

   genvar gi;
   for (gi = 0; gi < 2; gi++) begin : g_half
      shs_lane #(.LANE_W(HW)) u_lane (
         .a_i      (h_a[gi]),
         .b_i      (h_b[gi]),
         .sub_i    (h_sub[gi]),
         .wrap_o   (h_wrap[gi]),
         .half_o   (h_half[gi]),
         .nonneg_o (h_nn[gi])
      );
   end

   for (gi = 0; gi < NB; gi++) begin : g_byte
      shs_lane #(.LANE_W(BW)) u_lane (
         .a_i      (first_operand_i[gi*BW +: BW]),
         .b_i      (second_operand_i[gi*BW +: BW]),
         .sub_i    (1'b1),
         .wrap_o   (b_wrap[gi]),
         .half_o   (b_half[gi]),
         .nonneg_o (b_nn[gi])
      );
   end

   // ***************************************************
   // Result, write-back and flag selection
   // ***************************************************
   logic [WORD_W-1:0] res;
   logic              writes_reg;
   logic [WORD_W-1:0] test_val;
   logic              is_test;

   assign is_test  = (op == shs_pkg::SHS_OP_TAND) || (op == shs_pkg::SHS_OP_TXOR);
   assign test_val = (op == shs_pkg::SHS_OP_TAND) ?
                     (first_operand_i & second_operand_i) :
                     (first_operand_i ^ second_operand_i);

   // Result word and GE update per operation
   always_comb begin
      res        = shs_pkg::WORD_RST;
      writes_reg = 1'b1;
      ge_next    = ge_reg;
      flags_next = flags_reg;
      case (op)
         shs_pkg::SHS_OP_HASX,
         shs_pkg::SHS_OP_HSAX,
         shs_pkg::SHS_OP_HSUB16: begin
            res = {h_half[1], h_half[0]};
         end
         shs_pkg::SHS_OP_HSUB8: begin
            for (int i = 0; i < NB; i++) begin
               res[i*BW +: BW] = b_half[i];
            end
         end
         shs_pkg::SHS_OP_SUB16: begin
            res     = {h_wrap[1], h_wrap[0]};
            ge_next = {{2{h_nn[1]}}, {2{h_nn[0]}}};
         end
         shs_pkg::SHS_OP_SUB8: begin
            for (int i = 0; i < NB; i++) begin
               res[i*BW +: BW] = b_wrap[i];
               ge_next[i]      = b_nn[i];
            end
         end
         shs_pkg::SHS_OP_TAND,
         shs_pkg::SHS_OP_TXOR: begin
            writes_reg                 = 1'b0;
            res                        = test_val;
            flags_next[shs_pkg::FLAG_N] = test_val[WORD_W-1];
            flags_next[shs_pkg::FLAG_Z] = (test_val == shs_pkg::WORD_RST);
            if (shifter_carry_valid_i) begin
               flags_next[shs_pkg::FLAG_C] = shifter_carry_i;
            end
         end
         default: begin
            writes_reg = 1'b0;
         end
      endcase
   end

   // ***************************************************
   // State registers
   // ***************************************************
   // Condition flags: only tests touch them; V is never written here
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         flags_reg <= shs_pkg::FLAGS_RST;
      end else if (clk_en_i && fire && is_test) begin
         flags_reg <= flags_next;
      end
   end

   // Lane greater-or-equal flags
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         ge_reg <= shs_pkg::GE_RST;
      end else if (clk_en_i && fire) begin
         ge_reg <= ge_next;
      end
   end

   // Write-back port; test results are still shown but never enabled
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         result_o     <= shs_pkg::WORD_RST;
         result_idx_o <= shs_pkg::IDX_RST;
         result_we_o  <= 1'b0;
      end else if (clk_en_i) begin
         result_we_o <= fire & writes_reg;
         if (fire) begin
            result_o     <= res;
            result_idx_o <= dest_present_i ? dest_idx_i : first_operand_idx_i;
         end
      end
   end

   // Completion strobe and misuse flag; misuse is reported, not blocked,
   // since the decoder is trusted to keep SP and PC out.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         done_o          <= 1'b0;
         operand_fault_o <= 1'b0;
      end else if (clk_en_i) begin
         done_o          <= op_valid_i;
         operand_fault_o <= op_valid_i &&
                            (first_operand_idx_i == shs_pkg::IDX_SP ||
                             first_operand_idx_i == shs_pkg::IDX_PC ||
                             (dest_present_i && (dest_idx_i == shs_pkg::IDX_SP ||
                                                 dest_idx_i == shs_pkg::IDX_PC)));
      end
   end

   assign flags_o                    = flags_reg;
   assign lane_greater_equal_flags_o = ge_reg;

endmodule : shs_alu

// file: hw/shs_lane.sv
// Purpose : One signed lane: full-width difference/sum and its halved form.
// Assumes : Operands are two's complement of width LANE_W.
// Notes   : The sum is built one bit wider so halving never wraps.
`timescale 1ns/10ps
module shs_lane #(
   parameter int LANE_W = 8
) (
   input  wire logic [LANE_W-1:0] a_i,
   input  wire logic [LANE_W-1:0] b_i,
   input  wire logic              sub_i,
   output logic      [LANE_W-1:0] wrap_o,
   output logic      [LANE_W-1:0] half_o,
   output logic                   nonneg_o
);

   logic signed [LANE_W:0] wide;

   // ***************************************************
   // Elaboration check
   // ***************************************************
   if (LANE_W < 2) begin : g_bad_width
      $error("shs_lane: LANE_W must be at least 2");
   end

   // Sign-extended arithmetic one bit wider than the lane
   always_comb begin
      if (sub_i) begin
         wide = $signed({a_i[LANE_W-1], a_i}) - $signed({b_i[LANE_W-1], b_i});
      end else begin
         wide = $signed({a_i[LANE_W-1], a_i}) + $signed({b_i[LANE_W-1], b_i});
      end
   end

   // Low bits, halved bits (arithmetic shift by one) and sign test
   assign wrap_o   = wide[LANE_W-1:0];
   assign half_o   = wide[LANE_W:1];
   assign nonneg_o = ~wide[LANE_W];

endmodule : shs_lane

// file: hw/shs_pkg.sv
// Purpose : Shared constants and types for the SIMD halving subtract / test ALU slice.
// Assumes : 32-bit data words, condition codes in the usual four-bit encoding.
// Notes   : Flag bit positions follow the N Z C V order of the status nibble.
package shs_pkg;

   // ***************************************************
   // Widths and lane geometry
   // ***************************************************
   localparam int WORD_W   = 32;
   localparam int HALF_W   = 16;
   localparam int BYTE_W   = 8;
   localparam int REG_IDX_W = 4;
   localparam int COND_W   = 4;
   localparam int GE_W     = 4;

   // ***************************************************
   // Flag nibble positions and reset values
   // ***************************************************
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;
   localparam logic [3:0]        FLAGS_RST  = 4'h0;
   localparam logic [GE_W-1:0]   GE_RST     = 4'h0;
   localparam logic [WORD_W-1:0] WORD_RST   = 32'h0000_0000;
   localparam logic [REG_IDX_W-1:0] IDX_RST = 4'h0;

   // Register indices software must not name as operands
   localparam logic [REG_IDX_W-1:0] IDX_SP = 4'hD;
   localparam logic [REG_IDX_W-1:0] IDX_PC = 4'hF;

   // ***************************************************
   // Operation select codes
   // ***************************************************
   typedef enum logic [2:0] {
      SHS_OP_HASX  = 3'h0,   // signed_halving_add_sub_exchange
      SHS_OP_HSAX  = 3'h1,   // signed_halving_sub_add_exchange
      SHS_OP_HSUB16 = 3'h2,  // signed_halving_halfword_subtract
      SHS_OP_HSUB8 = 3'h3,   // signed_halving_byte_subtract
      SHS_OP_SUB16 = 3'h4,   // signed_parallel_halfword_subtract
      SHS_OP_SUB8  = 3'h5,   // signed_parallel_byte_subtract
      SHS_OP_TAND  = 3'h6,   // bit_test_and
      SHS_OP_TXOR  = 3'h7    // equivalence_test_xor
   } shs_op_t;

   // Condition codes
   localparam logic [COND_W-1:0] CC_EQ = 4'h0;
   localparam logic [COND_W-1:0] CC_NE = 4'h1;
   localparam logic [COND_W-1:0] CC_CS = 4'h2;
   localparam logic [COND_W-1:0] CC_CC = 4'h3;
   localparam logic [COND_W-1:0] CC_MI = 4'h4;
   localparam logic [COND_W-1:0] CC_PL = 4'h5;
   localparam logic [COND_W-1:0] CC_VS = 4'h6;
   localparam logic [COND_W-1:0] CC_VC = 4'h7;
   localparam logic [COND_W-1:0] CC_HI = 4'h8;
   localparam logic [COND_W-1:0] CC_LS = 4'h9;
   localparam logic [COND_W-1:0] CC_GE = 4'hA;
   localparam logic [COND_W-1:0] CC_LT = 4'hB;
   localparam logic [COND_W-1:0] CC_GT = 4'hC;
   localparam logic [COND_W-1:0] CC_LE = 4'hD;
   localparam logic [COND_W-1:0] CC_AL = 4'hE;

endpackage : shs_pkg

// file: tb/shs_alu_asserts.sv
// Purpose : Port-level checker for the halving / parallel subtract slice.
// Assumes : Single clock domain, synchronous active-low reset.
// Notes   : Lane figures rebuilt from operands, one bit wider than the lane.
`timescale 1ns/10ps
module shs_alu_asserts (
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic        clk_en_i,
   input wire logic        op_valid_i,
   input wire logic [2:0]  op_sel_i,
   input wire logic [3:0]  cond_i,
   input wire logic [31:0] first_operand_i,
   input wire logic [31:0] second_operand_i,
   input wire logic        shifter_carry_i,
   input wire logic        shifter_carry_valid_i,
   input wire logic [3:0]  first_operand_idx_i,
   input wire logic        dest_present_i,
   input wire logic [31:0] result_o,
   input wire logic [3:0]  result_idx_o,
   input wire logic        result_we_o,
   input wire logic [3:0]  flags_o,
   input wire logic [3:0]  lane_greater_equal_flags_o,
   input wire logic        done_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   logic signed [16:0] dlo, dhi;
   logic [3:0]  ge8, ge16;
   logic [31:0] res16, tres;
   // Reference lane differences; wide form keeps the sign of every lane
   always_comb begin
      dlo = $signed({first_operand_i[15], first_operand_i[15:0]})
          - $signed({second_operand_i[15], second_operand_i[15:0]});
      dhi = $signed({first_operand_i[31], first_operand_i[31:16]})
          - $signed({second_operand_i[31], second_operand_i[31:16]});
      ge16 = {{2{~dhi[16]}}, {2{~dlo[16]}}};
      res16 = {dhi[15:0], dlo[15:0]};
      tres = op_sel_i[0] ? (first_operand_i ^ second_operand_i)
                         : (first_operand_i & second_operand_i);
      for (int i = 0; i < 4; i++) begin
         ge8[i] = ($signed({first_operand_i[8*i+7], first_operand_i[8*i+:8]})
                 - $signed({second_operand_i[8*i+7], second_operand_i[8*i+:8]})) >= 0;
      end
   end
   // An operation taken with an always-true condition
   sequence s_go;
      clk_en_i && op_valid_i && cond_i == shs_pkg::CC_AL;
   endsequence
   sequence s_test;
      s_go ##0 op_sel_i >= 3'h6;
   endsequence
   done_after_op_a: assert property (clk_en_i && op_valid_i |=> done_o)
      else $error("done missing after op");
   cond_fail_a: assert property (clk_en_i && op_valid_i && cond_i == shs_pkg::CC_EQ
      && !flags_o[shs_pkg::FLAG_Z] |=> !result_we_o && $stable(flags_o) && $stable(result_o))
      else $error("failed condition changed state");
   test_no_write_a: assert property (s_test |=> !result_we_o
      && $stable(lane_greater_equal_flags_o)) else $error("test op wrote");
   test_nz_a: assert property (s_test |=> flags_o[3] == $past(tres[31])
      && flags_o[2] == ($past(tres) == 32'h0)) else $error("test N or Z wrong");
   test_v_hold_a: assert property (s_test |=> $stable(flags_o[0]))
      else $error("test op changed V");
   test_carry_a: assert property (s_test ##0 shifter_carry_valid_i
      |=> flags_o[1] == $past(shifter_carry_i)) else $error("test carry not loaded");
   halving_flags_a: assert property (s_go ##0 op_sel_i < 3'h4 |=> $stable(flags_o))
      else $error("halving op changed flags");
   sub16_res_a: assert property (s_go ##0 op_sel_i == 3'h4 |=> result_o == $past(res16))
      else $error("halfword difference wrong");
   sub16_ge_a: assert property (s_go ##0 op_sel_i == 3'h4
      |=> lane_greater_equal_flags_o == $past(ge16)) else $error("halfword GE wrong");
   sub8_ge_a: assert property (s_go ##0 op_sel_i == 3'h5
      |=> lane_greater_equal_flags_o == $past(ge8)) else $error("byte GE wrong");
   dest_default_a: assert property (s_go ##0 op_sel_i < 3'h6 && !dest_present_i
      |=> result_we_o && result_idx_o == $past(first_operand_idx_i))
      else $error("default destination wrong");
endmodule : shs_alu_asserts
bind shs_alu shs_alu_asserts i_chk (.*);

// file: tb/shs_rf_model.sv
// Purpose : Register file standing behind the slice's write port.
// Assumes : One write per cycle, index and data qualified by the write pulse.
// Notes   : No reset; unwritten entries stay unknown so stray reads show.
`timescale 1ns/10ps
module shs_rf_model (
   input  wire logic                            mclk_i,
   input  wire logic                            we_i,
   input  wire logic [shs_pkg::REG_IDX_W-1:0]   idx_i,
   input  wire logic [shs_pkg::WORD_W-1:0]      data_i,
   output logic      [shs_pkg::WORD_W-1:0]      regs_o [16]
);
   // Capture a result only on the write pulse
   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         regs_o[idx_i] <= data_i;
      end
   end
endmodule : shs_rf_model

// file: tb/tb_top.sv
// Purpose : Self-checking bench for the halving / parallel subtract slice.
// Assumes : Inputs change on the falling edge, results read one edge later.
// Notes   : Expectations come from a lane model written here.
`timescale 1ns/10ps
module tb_top;
   logic        mclk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, op_valid_i = 1'b0;
   logic [2:0]  op_sel_i = 3'h0;
   logic [3:0]  cond_i = 4'hE, first_operand_idx_i = 4'h1, dest_idx_i = 4'h2;
   logic [31:0] first_operand_i = 32'h0, second_operand_i = 32'h0, result_o;
   logic        shifter_carry_i = 1'b0, shifter_carry_valid_i = 1'b0, dest_present_i = 1'b1;
   logic [3:0]  result_idx_o, flags_o, lane_greater_equal_flags_o;
   logic        result_we_o, done_o, operand_fault_o;
   logic [31:0] regs [16];
   int          error_cnt = 0, num_checks = 0, cyc = 0;
   always #12.5 mclk_i = ~mclk_i;
   shs_alu i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
      .op_valid_i(op_valid_i), .op_sel_i(op_sel_i), .cond_i(cond_i),
      .first_operand_i(first_operand_i), .second_operand_i(second_operand_i),
      .shifter_carry_i(shifter_carry_i), .shifter_carry_valid_i(shifter_carry_valid_i),
      .first_operand_idx_i(first_operand_idx_i), .dest_idx_i(dest_idx_i),
      .dest_present_i(dest_present_i), .result_o(result_o), .result_idx_o(result_idx_o),
      .result_we_o(result_we_o), .flags_o(flags_o), .done_o(done_o),
      .lane_greater_equal_flags_o(lane_greater_equal_flags_o),
      .operand_fault_o(operand_fault_o));
   shs_rf_model i_rf (.mclk_i(mclk_i), .we_i(result_we_o), .idx_i(result_idx_o),
      .data_i(result_o), .regs_o(regs));
   task automatic stop_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // Hang guard; the whole run needs well under a hundred cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 1000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Called at a falling edge; returns at the next one with the answer settled
   task automatic issue(input logic [2:0] op, input logic [3:0] c, input logic [31:0] a, b);
      op_valid_i = 1'b1;
      op_sel_i = op;
      cond_i = c;
      first_operand_i = a;
      second_operand_i = b;
      @(negedge mclk_i);
   endtask : issue
   task automatic idle;
      op_valid_i = 1'b0;
      @(negedge mclk_i);
   endtask : idle
   // Lane model for ops 0..5, sums one bit wider before halving
   function automatic void ref_calc(input logic [2:0] op, input logic [31:0] a, b,
                                    output logic [31:0] r, output logic [3:0] g);
      logic signed [16:0] h1, h0;
      logic signed [8:0]  q;
      h1 = $signed({a[31], a[31:16]}) - $signed({b[31], b[31:16]});
      h0 = $signed({a[15], a[15:0]}) - $signed({b[15], b[15:0]});
      if (op == 3'h0) begin
         h1 = $signed({a[31], a[31:16]}) + $signed({b[15], b[15:0]});
         h0 = $signed({a[15], a[15:0]}) - $signed({b[31], b[31:16]});
      end
      if (op == 3'h1) begin
         h1 = $signed({a[31], a[31:16]}) - $signed({b[15], b[15:0]});
         h0 = $signed({a[15], a[15:0]}) + $signed({b[31], b[31:16]});
      end
      r = (op == 3'h4) ? {h1[15:0], h0[15:0]} : {h1[16:1], h0[16:1]};
      g = {{2{~h1[16]}}, {2{~h0[16]}}};
      for (int i = 0; i < 4; i++) begin
         q = $signed({a[8*i+7], a[8*i+:8]}) - $signed({b[8*i+7], b[8*i+:8]});
         if (op == 3'h3 || op == 3'h5) begin
            r[8*i+:8] = (op == 3'h3) ? q[8:1] : q[7:0];
            g[i] = ~q[8];
         end
      end
   endfunction : ref_calc
   // Condition outcome with flags N=1 Z=0 C=1 V=0
   function automatic logic pass(input logic [3:0] c);
      logic [7:0] t;
      t = 8'h16;
      return (c[3:1] == 3'h7) ? 1'b1 : (t[c[3:1]] ^ c[0]);
   endfunction : pass
   task automatic t_tests;
      issue(shs_pkg::SHS_OP_TXOR, shs_pkg::CC_AL, 32'h1234_5678, 32'h1234_5678);
      chk(flags_o, 4'h4);
      chk(result_we_o, 1'b0);
      shifter_carry_i = 1'b1;
      shifter_carry_valid_i = 1'b1;
      issue(shs_pkg::SHS_OP_TAND, shs_pkg::CC_AL, 32'h8000_00F0, 32'hF000_0000);
      chk(flags_o, 4'hA);
      chk(result_we_o, 1'b0);
      shifter_carry_valid_i = 1'b0;
   endtask : t_tests
   task automatic t_lanes;
      logic [31:0] r;
      logic [3:0]  g;
      logic [31:0] exp_r [6];
      for (int op = 0; op < 6; op++) begin
         dest_idx_i = 4'(op + 1);
         issue(3'(op), shs_pkg::CC_AL, 32'h7FFF_8001, 32'h8000_7F80 ^ (op * 32'h0101_0101));
         ref_calc(3'(op), 32'h7FFF_8001, 32'h8000_7F80 ^ (op * 32'h0101_0101), r, g);
         exp_r[op] = r;
         chk(result_o, r);
         chk(flags_o, 4'hA);
         chk(lane_greater_equal_flags_o, (op < 4) ? 4'h0 : g);
      end
      // The register file captures one edge after the write pulse
      idle();
      for (int op = 0; op < 6; op++) begin
         chk(regs[op+1], exp_r[op]);
      end
   endtask : t_lanes
   task automatic t_cond;
      for (int c = 0; c < 16; c++) begin
         issue(shs_pkg::SHS_OP_SUB16, 4'(c), 32'h0000_0100 + c, 32'h0000_0001);
         chk(done_o, 1'b1);
         chk(result_we_o, pass(4'(c)));
      end
      idle();
      clk_en_i = 1'b0;
      issue(shs_pkg::SHS_OP_SUB8, shs_pkg::CC_AL, 32'h1, 32'h2);
      chk(done_o, 1'b0);
      chk(lane_greater_equal_flags_o, 4'hF);
      clk_en_i = 1'b1;
      idle();
   endtask : t_cond
   task automatic t_dest;
      logic [31:0] r;
      logic [3:0]  g;
      dest_present_i = 1'b0;
      first_operand_idx_i = 4'h5;
      issue(shs_pkg::SHS_OP_HSUB16, shs_pkg::CC_AL, 32'h0004_8000, 32'h0002_7FFF);
      ref_calc(3'h2, 32'h0004_8000, 32'h0002_7FFF, r, g);
      chk(result_idx_o, 4'h5);
      chk(operand_fault_o, 1'b0);
      first_operand_idx_i = shs_pkg::IDX_SP;
      issue(shs_pkg::SHS_OP_HSUB8, shs_pkg::CC_AL, 32'h1, 32'h1);
      chk(regs[5], r);
      chk(operand_fault_o, 1'b1);
      first_operand_idx_i = 4'h5;
      idle();
   endtask : t_dest
   // Reset for four cycles, then each scenario in turn
   initial begin
      repeat (4) @(negedge mclk_i);
      reset_n_i = 1'b1;
      chk({result_o[3:0], flags_o, lane_greater_equal_flags_o, done_o, result_we_o}, 32'h0);
      t_tests();
      t_lanes();
      t_cond();
      t_dest();
      stop_test();
   end
endmodule : tb_top
